/* File: pkg/rtc_pkg.sv */
// Constants, types and helpers for the battery-backed RAM with clock.
// Assumes a single 125 MHz clock and bus pins sampled synchronously.
// Summary of operation
// - 15-bit address selects one of 32768 bytes
// - Chip select low, write high: read
// - Data drives only with select and output enable
// - Early enabled outputs undefined until address access
// - Address change: old data held, then undefined
// - Valid only after later enable access delay
// - Top eight bytes hold the clock
// - BCD time and calendar, 24-hour hours
// - Date rolls over by month length, leap
// - Lowest clock byte is clock control
// - Clock bytes refreshed from counters each second
// - Clock bytes use ordinary memory cycles
// - Supply fault blocks every array write
// - On battery, data and clock kept
// - Write spans later fall to earlier rise
// - Control bit six freezes clock byte updates
// - Bad battery at power-up discards first write
package rtc_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [14:0] ADDR_CLOCK_BASE = 15'h7FF8;  // First clock byte
    localparam int          ARRAY_LAST      = 32759;     // Last plain RAM byte
    localparam logic [2:0]  OFS_CONTROL     = 3'h0;      // Clock control
    localparam logic [2:0]  OFS_SECONDS     = 3'h1;
    localparam logic [2:0]  OFS_MINUTES     = 3'h2;
    localparam logic [2:0]  OFS_HOURS       = 3'h3;
    localparam logic [2:0]  OFS_DAY         = 3'h4;      // Day of week
    localparam logic [2:0]  OFS_DATE        = 3'h5;
    localparam logic [2:0]  OFS_MONTH       = 3'h6;
    localparam logic [2:0]  OFS_YEAR        = 3'h7;
    localparam int          CTRL_HALT_BIT   = 6;         // Freeze clock bytes

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_ZERO    = 8'h00;          // Seconds, minutes, hours, year
    localparam logic [7:0] RST_ONE     = 8'h01;          // Day, date, month

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS     = 8;
    localparam int ADDRESS_ACCESS_NS   = 70;             // Address access delay
    localparam int SELECT_ACCESS_NS    = 70;             // Select access delay
    localparam int OE_ACCESS_NS        = 35;             // Output enable access delay
    localparam int OUTPUT_HOLD_NS      = 5;              // Output hold interval
    localparam int SECOND_MS           = 1000;
    localparam int ADDR_ACCESS_CYC = (ADDRESS_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SEL_ACCESS_CYC  = (SELECT_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int OE_ACCESS_CYC   = (OE_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int HOLD_CYC        = (OUTPUT_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SECOND_CYC      = SECOND_MS * 1000000 / CLOCK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } rtc_time_type;

    // Bus access mode, Gray along idle, read, write
    typedef enum logic [1:0] {
        RTC_IDLE  = 2'b00,
        RTC_READ  = 2'b01,
        RTC_WRITE = 2'b11
    } rtc_access_type;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clock byte test
    function automatic logic rtcIsClock(input logic [14:0] addr);
        return addr >= ADDR_CLOCK_BASE;
    endfunction

    // BCD step with wrap; bit 8 is the carry out
    function automatic logic [8:0] rtcBcdStep(input logic [7:0] v, input logic [7:0] last,
                                              input logic [7:0] first);
        if (v == last) begin
            return {1'b1, first};
        end else if (v[3:0] == 4'h9) begin
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        return {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction

    // Last date of a month in BCD, leap years every fourth year
    function automatic logic [7:0] rtcMonthLast(input logic [7:0] month, input logic [7:0] year);
        logic leap;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
        if (month == 8'h02) begin
            return leap ? 8'h29 : 8'h28;
        end else if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h11) begin
            return 8'h30;
        end
        return 8'h31;
    endfunction

endpackage

/* File: hdl/rtc_calendar.sv */
// Timekeeping counters: seconds through year in BCD.
// Assumes a one-cycle second tick and field loads from the bus side.
`timescale 1ns/10ps
`default_nettype none
module rtc_calendar (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  tick,       // One pulse per second
    input  wire logic                  load,       // Preset one field
    input  wire logic [2:0]            loadIndex,  // Clock byte offset
    input  wire logic [7:0]            loadData,
    output rtc_pkg::rtc_time_type      count       // Running count
);

    // ------------------------------------------------------------
    // Carry chain
    // ------------------------------------------------------------
    logic [8:0] secStep;
    logic [8:0] minStep;
    logic [8:0] hourStep;
    logic [8:0] dayStep;
    logic [8:0] dateStep;
    logic [8:0] monthStep;
    logic [8:0] yearStep;
    rtc_pkg::rtc_time_type next_count;

    assign secStep   = rtc_pkg::rtcBcdStep(count.seconds, 8'h59, 8'h00);
    assign minStep   = rtc_pkg::rtcBcdStep(count.minutes, 8'h59, 8'h00);
    assign hourStep  = rtc_pkg::rtcBcdStep(count.hours, 8'h23, 8'h00);
    assign dayStep   = rtc_pkg::rtcBcdStep(count.day, 8'h07, 8'h01);
    assign dateStep  = rtc_pkg::rtcBcdStep(count.date,
                           rtc_pkg::rtcMonthLast(count.month, count.year), 8'h01);
    assign monthStep = rtc_pkg::rtcBcdStep(count.month, 8'h12, 8'h01);
    assign yearStep  = rtc_pkg::rtcBcdStep(count.year, 8'h99, 8'h00);

    // Next count: a load wins over the tick in its cycle
    always_comb begin
        next_count = count;
        if (load) begin
            unique case (loadIndex)
                rtc_pkg::OFS_SECONDS: next_count.seconds = loadData;
                rtc_pkg::OFS_MINUTES: next_count.minutes = loadData;
                rtc_pkg::OFS_HOURS:   next_count.hours   = loadData;
                rtc_pkg::OFS_DAY:     next_count.day     = loadData;
                rtc_pkg::OFS_DATE:    next_count.date    = loadData;
                rtc_pkg::OFS_MONTH:   next_count.month   = loadData;
                rtc_pkg::OFS_YEAR:    next_count.year    = loadData;
                default:              next_count = count;   // Control byte loads nothing
            endcase
        end else if (tick) begin
            next_count.seconds = secStep[7:0];
            if (secStep[8]) begin
                next_count.minutes = minStep[7:0];
                if (minStep[8]) begin
                    next_count.hours = hourStep[7:0];
                    if (hourStep[8]) begin
                        next_count.day  = dayStep[7:0];
                        next_count.date = dateStep[7:0];
                        if (dateStep[8]) begin
                            next_count.month = monthStep[7:0];
                            if (monthStep[8]) begin
                                next_count.year = yearStep[7:0];
                            end
                        end
                    end
                end
            end
        end
    end

    // Counter register, runs whether on supply or battery
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= '{rtc_pkg::RST_ZERO, rtc_pkg::RST_ONE, rtc_pkg::RST_ONE, rtc_pkg::RST_ONE,
                       rtc_pkg::RST_ZERO, rtc_pkg::RST_ZERO, rtc_pkg::RST_ZERO};
        end else begin
            count <= next_count;
        end
    end

endmodule // rtc_calendar
`default_nettype wire

/* File: hdl/rtc_sram_clock.sv */
// Byte-wide static RAM whose top eight bytes mirror a calendar clock.
// Assumes bus pins synchronous to clock and power conditions as levels.
`timescale 1ns/10ps
`default_nettype none
module rtc_sram_clock #(
    parameter int SECOND_CYCLES = rtc_pkg::SECOND_CYC   // Cycles per second tick
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [14:0] byteAddress,     // Byte address
    input  wire logic [7:0]  dataLinesIn,     // Data lines, pin level
    output logic [7:0]       dataLinesOut,    // Data lines, driven value
    output logic             dataDriveN,      // Low while driving data lines
    output logic             dataValid,       // Driven data is meaningful
    input  wire logic        chipEnableN,
    input  wire logic        outputEnableN,
    input  wire logic        writeEnableN,
    input  wire logic        supplyFault,     // Supply below fault threshold
    input  wire logic        onBattery,       // Supply below switch threshold
    input  wire logic        batteryLow,      // Battery below bad level
    output logic             batteryBadFlag   // Battery found bad at power-up
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0]  memArray [0:rtc_pkg::ARRAY_LAST];   // Plain RAM bytes
    logic [7:0]  clockBytes [0:7];                   // Shared clock bytes
    rtc_pkg::rtc_time_type count;                    // Live counters
    rtc_pkg::rtc_access_type access;                 // Current bus mode
    rtc_pkg::rtc_access_type next_access;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic        powerOk;         // Neither fault nor battery
    logic        selected;
    logic        readDrive;       // Outputs may drive
    logic        writeActive;
    logic        commit;          // Write end seen
    logic        commitOk;        // Write allowed to land
    logic        commitClock;     // Landing in clock bytes
    logic        halt;            // Clock byte freeze
    logic [7:0]  readData;
    logic [14:0] lastAddr;
    logic        addrChanged;
    logic [14:0] wrAddr;          // Address held during write
    logic [7:0]  wrData;          // Last data seen during write
    logic        wasWriting;
    logic [3:0]  addrAge;         // Cycles since address settled
    logic [3:0]  selAge;          // Cycles since chip select
    logic [3:0]  oeAge;           // Cycles since output enable
    logic [3:0]  holdCount;       // Old data hold left
    logic        accessReady;
    logic [26:0] secondCount;
    logic        tick;
    logic        strapTaken;

    assign powerOk     = !supplyFault && !onBattery;
    assign selected    = !chipEnableN && powerOk;
    assign readDrive   = selected && writeEnableN && !outputEnableN;
    assign writeActive = selected && !writeEnableN;
    assign next_access = writeActive ? rtc_pkg::RTC_WRITE
                       : (selected ? rtc_pkg::RTC_READ : rtc_pkg::RTC_IDLE);
    assign commit      = wasWriting && !writeActive;
    assign commitOk    = commit && powerOk && !batteryBadFlag;
    assign commitClock = commitOk && rtc_pkg::rtcIsClock(wrAddr);
    assign halt        = clockBytes[rtc_pkg::OFS_CONTROL][rtc_pkg::CTRL_HALT_BIT];
    assign readData    = rtc_pkg::rtcIsClock(byteAddress) ? clockBytes[byteAddress[2:0]]
                                                          : memArray[byteAddress];
    assign addrChanged = byteAddress != lastAddr;
    assign accessReady = addrAge >= 4'(rtc_pkg::ADDR_ACCESS_CYC)
                      && selAge >= 4'(rtc_pkg::SEL_ACCESS_CYC)
                      && oeAge >= 4'(rtc_pkg::OE_ACCESS_CYC);
    assign tick        = secondCount == 27'(SECOND_CYCLES - 1);

    // ------------------------------------------------------------
    // Timekeeping
    // ------------------------------------------------------------
    // Second divider
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            secondCount <= '0;
        end else begin
            secondCount <= tick ? '0 : secondCount + 27'h1;
        end
    end

    // Counters; a clock byte write presets its field
    rtc_calendar u_calendar (
        .clock     (clock),
        .rst       (rst),
        .tick      (tick),
        .load      (commitClock),
        .loadIndex (wrAddr[2:0]),
        .loadData  (wrData),
        .count     (count)
    );

    // Clock bytes: bus write wins, else refresh each second unless frozen
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clockBytes[0] <= rtc_pkg::RST_CONTROL;
            for (int i = 1; i < 8; i++) begin
                clockBytes[i] <= rtc_pkg::RST_ZERO;
            end
        end else if (commitClock) begin
            clockBytes[wrAddr[2:0]] <= wrData;
        end else if (tick && !halt) begin
            clockBytes[rtc_pkg::OFS_SECONDS] <= count.seconds;
            clockBytes[rtc_pkg::OFS_MINUTES] <= count.minutes;
            clockBytes[rtc_pkg::OFS_HOURS]   <= count.hours;
            clockBytes[rtc_pkg::OFS_DAY]     <= count.day;
            clockBytes[rtc_pkg::OFS_DATE]    <= count.date;
            clockBytes[rtc_pkg::OFS_MONTH]   <= count.month;
            clockBytes[rtc_pkg::OFS_YEAR]    <= count.year;
        end
    end

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    // Track the write window and the last data seen in it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wasWriting <= 1'b0;
            wrAddr     <= '0;
            wrData     <= '0;
        end else begin
            wasWriting <= writeActive;
            if (writeActive) begin
                wrAddr <= byteAddress;
                wrData <= dataLinesIn;
            end
        end
    end

    // Plain array bytes, no reset so contents survive
    always_ff @(posedge clock) begin
        if (commitOk && !rtc_pkg::rtcIsClock(wrAddr)) begin
            memArray[wrAddr] <= wrData;
        end
    end

    // Battery check once after release, cleared by first write attempt
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strapTaken     <= 1'b0;
            batteryBadFlag <= 1'b0;
        end else if (!strapTaken) begin
            strapTaken     <= 1'b1;
            batteryBadFlag <= batteryLow;
        end else if (commit && powerOk) begin
            batteryBadFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Access age counters, saturating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            access    <= rtc_pkg::RTC_IDLE;
            lastAddr  <= '0;
            addrAge   <= '0;
            selAge    <= '0;
            oeAge     <= '0;
            holdCount <= '0;
        end else begin
            access   <= next_access;
            lastAddr <= byteAddress;
            addrAge  <= addrChanged ? 4'h0 : (addrAge == 4'hF ? addrAge : addrAge + 4'h1);
            selAge   <= !selected ? 4'h0 : (selAge == 4'hF ? selAge : selAge + 4'h1);
            oeAge    <= outputEnableN ? 4'h0 : (oeAge == 4'hF ? oeAge : oeAge + 4'h1);
            if (addrChanged && dataValid && readDrive) begin
                holdCount <= 4'(rtc_pkg::HOLD_CYC);
            end else if (holdCount != 4'h0) begin
                holdCount <= holdCount - 4'h1;
            end
        end
    end

    // Data line drive; old data stands through the hold interval
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dataDriveN   <= 1'b1;
            dataLinesOut <= '0;
            dataValid    <= 1'b0;
        end else begin
            dataDriveN <= !readDrive;
            if (!readDrive) begin
                dataValid    <= 1'b0;
                dataLinesOut <= '0;
            end else if ((addrChanged && dataValid) || holdCount != 4'h0) begin
                dataValid    <= dataValid;
            end else begin
                dataValid    <= accessReady && !addrChanged;
                dataLinesOut <= readData;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_array_write;
        @(posedge clock) disable iff (rst)
        commitOk && !rtc_pkg::rtcIsClock(wrAddr) |=> memArray[$past(wrAddr)] == $past(wrData);
    endproperty
    a_array_write: assert property (p_array_write) else $error("array write lost");

    property p_drive_only_read;
        @(posedge clock) disable iff (rst)
        !dataDriveN |-> $past(!chipEnableN && !outputEnableN && writeEnableN && powerOk);
    endproperty
    a_drive_only_read: assert property (p_drive_only_read) else $error("bad drive");

    property p_read_mode;
        @(posedge clock) disable iff (rst)
        !chipEnableN && writeEnableN && powerOk |=> access == rtc_pkg::RTC_READ;
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("read not entered");

    property p_addr_access;
        @(posedge clock) disable iff (rst)
        $rose(dataValid) |-> $past(addrAge) >= 4'(rtc_pkg::ADDR_ACCESS_CYC);
    endproperty
    a_addr_access: assert property (p_addr_access) else $error("data too early");

    property p_hold_old;
        @(posedge clock) disable iff (rst)
        readDrive && dataValid && addrChanged |=> dataValid && $stable(dataLinesOut);
    endproperty
    a_hold_old: assert property (p_hold_old) else $error("hold not kept");

    property p_enable_access;
        @(posedge clock) disable iff (rst)
        $rose(dataValid) |-> $past(selAge) >= 4'(rtc_pkg::SEL_ACCESS_CYC)
                          && $past(oeAge) >= 4'(rtc_pkg::OE_ACCESS_CYC);
    endproperty
    a_enable_access: assert property (p_enable_access) else $error("enable too early");

    property p_second_refresh;
        @(posedge clock) disable iff (rst)
        tick && !halt && !commitClock |=> clockBytes[rtc_pkg::OFS_SECONDS] == $past(count.seconds);
    endproperty
    a_second_refresh: assert property (p_second_refresh) else $error("no refresh");

    property p_freeze;
        @(posedge clock) disable iff (rst)
        halt && !commitClock |=> $stable(clockBytes[rtc_pkg::OFS_MINUTES]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen byte moved");

    property p_fault_block;
        @(posedge clock) disable iff (rst)
        !powerOk |-> !commitOk ##1 dataDriveN;
    endproperty
    a_fault_block: assert property (p_fault_block) else $error("write in fault");

    property p_bad_discard;
        @(posedge clock) disable iff (rst)
        batteryBadFlag && strapTaken && commit && powerOk |-> !commitOk ##1 !batteryBadFlag;
    endproperty
    a_bad_discard: assert property (p_bad_discard) else $error("bad battery write");

endmodule // rtc_sram_clock
`default_nettype wire

/* File: verification/rtc_host_model.sv */
// Host processor model on the byte-wide RAM bus.
// Assumes the device flags meaningful read data with dataValid.
`timescale 1ns/10ps
`default_nettype none
module rtc_host_model (
    input  wire logic   clock,
    input  wire logic   dataValid,
    output logic [14:0] byteAddress,
    output logic [7:0]  hostData,
    output logic        chipEnableN,
    output logic        outputEnableN,
    output logic        writeEnableN
);
    logic [7:0] wrData = 8'h00; // Held through a write
    logic [7:0] noise  = 8'h5A; // Released lines change every cycle
    initial begin
        byteAddress = 15'h0000;
        {chipEnableN, outputEnableN, writeEnableN} = 3'h7;
    end
    always @(negedge clock) noise <= ~noise;
    assign hostData = writeEnableN ? noise : wrData;
    // One-cycle write window, then strobes high
    task automatic hostWrite(input logic [14:0] a, input logic [7:0] d);
        @(negedge clock);
        byteAddress = a;
        wrData = d;
        {chipEnableN, writeEnableN} = 2'b00;
        @(negedge clock);
        {chipEnableN, writeEnableN} = 2'b11;
        @(negedge clock);
    endtask
    // Read held until valid is seen or limit runs out
    // A differing second address is moved to while still selected
    task automatic hostRead(input logic [14:0] a, input logic [14:0] b, output logic ok);
        logic seen;
        ok = 1'b1;
        @(negedge clock);
        byteAddress = a;
        {chipEnableN, outputEnableN} = 2'b00;
        for (int n = 0; n < 2; n++) begin
            seen = 1'b0;
            for (int i = 0; i < 20 && !seen; i++) begin
                @(negedge clock);
                seen = (dataValid === 1'b1);
            end
            ok = ok & seen;
            if (a == b) break;
            a = b;
            byteAddress = b;
            repeat (4) @(negedge clock);
        end
        @(negedge clock);
        {chipEnableN, outputEnableN} = 2'b11;
    endtask
endmodule // rtc_host_model
`default_nettype wire

/* File: verification/rtc_sram_clock_tb.sv */
// Self-checking bench for the RAM with calendar clock.
// Assumes the host model in rtc_host_model.sv.
`timescale 1ns/10ps
`default_nettype none
module rtc_sram_clock_tb;
    localparam int SEC = 400; // Short second
    logic clock = 1'b0, rst = 1'b1, supplyFault = 1'b0, onBattery = 1'b0, batteryLow = 1'b0;
    logic [14:0] byteAddress, a;
    logic [7:0]  hostData, dataLinesIn, dataLinesOut, d;
    logic dataDriveN, dataValid, chipEnableN, outputEnableN, writeEnableN, batteryBadFlag, ok;
    logic [7:0]  expQ[$]; // Expected read data
    logic        prevValid = 1'b0;
    int          nErrors = 0;
    int          numChecks = 0;
    logic [39:0] cal[3] = '{40'h01_02_28_03_01, 40'h04_02_28_02_29, 40'h01_04_30_05_01};
    always #4 clock = ~clock;
    assign dataLinesIn = dataDriveN ? hostData : dataLinesOut;
    rtc_sram_clock #(.SECOND_CYCLES(SEC)) u_rtc_sram_clock (.clock(clock), .rst(rst),
        .byteAddress(byteAddress), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
        .dataDriveN(dataDriveN), .dataValid(dataValid), .chipEnableN(chipEnableN),
        .outputEnableN(outputEnableN), .writeEnableN(writeEnableN), .supplyFault(supplyFault),
        .onBattery(onBattery), .batteryLow(batteryLow), .batteryBadFlag(batteryBadFlag));
    rtc_host_model host (.clock(clock), .dataValid(dataValid), .byteAddress(byteAddress),
        .hostData(hostData), .chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
        .writeEnableN(writeEnableN));
    task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
        numChecks++;
        if (g !== e) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    // Oldest note checked when valid data appears
    always @(negedge clock) begin
        if (dataValid === 1'b1 && !prevValid && dataDriveN === 1'b0) begin
            if (expQ.size() == 0) cmp("unexpected read", 8'h00, 8'hFF);
            else cmp("read data", expQ.pop_front(), dataLinesOut);
        end
        prevValid = (dataValid === 1'b1);
    end
    task automatic readExp(input logic [14:0] ad, input logic [7:0] e);
        expQ.push_back(e);
        host.hostRead(ad, ad, ok);
        cmp("read answered", 8'h01, {7'h0, ok});
    endtask
    task automatic cw(input logic [2:0] o, input logic [7:0] v);
        host.hostWrite(rtc_pkg::ADDR_CLOCK_BASE + 15'(o), v);
    endtask
    task automatic cr(input logic [2:0] o, input logic [7:0] e);
        readExp(rtc_pkg::ADDR_CLOCK_BASE + 15'(o), e);
    endtask
    task automatic doReset(input logic low);
        batteryLow = low;
        rst = 1'b1;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    initial begin
        void'($urandom(17094));
        doReset(1'b0);
        for (int i = 0; i < 6; i++) begin
            a = 15'($urandom_range(rtc_pkg::ARRAY_LAST, 512));
            d = 8'($urandom);
            host.hostWrite(a, d);
            readExp(a, d);
            repeat (2) @(negedge clock);
            cmp("drive released", 8'h01, {7'h0, dataDriveN});
        end
        $display("test ram done");
        host.hostWrite(15'h0123, 8'h55);
        expQ.push_back(d);
        expQ.push_back(8'h55);
        host.hostRead(a, 15'h0123, ok);
        cmp("moved read answered", 8'h01, {7'h0, ok});
        a = 15'h0123;
        for (int k = 0; k < 2; k++) begin
            {onBattery, supplyFault} = k ? 2'b10 : 2'b01;
            host.hostWrite(a, 8'hC3);
            host.hostRead(a, a, ok);
            cmp("read refused", 8'h00, {7'h0, ok});
            {onBattery, supplyFault} = 2'b00;
            readExp(a, 8'h55);
        end
        $display("test power done");
        doReset(1'b1);
        cmp("bad flag set", 8'h01, {7'h0, batteryBadFlag});
        batteryLow = 1'b0;
        host.hostWrite(a, 8'hAA);
        @(negedge clock);
        cmp("bad flag clear", 8'h00, {7'h0, batteryBadFlag});
        readExp(a, 8'h55);
        host.hostWrite(a, 8'h3C);
        readExp(a, 8'h3C);
        $display("test battery done");
        for (int i = 0; i < 3; i++) begin
            cw(rtc_pkg::OFS_CONTROL, 8'h00);
            cw(rtc_pkg::OFS_YEAR, cal[i][39:32]);
            cw(rtc_pkg::OFS_MONTH, cal[i][31:24]);
            cw(rtc_pkg::OFS_DATE, cal[i][23:16]);
            cw(rtc_pkg::OFS_HOURS, 8'h23);
            cw(rtc_pkg::OFS_MINUTES, 8'h59);
            cw(rtc_pkg::OFS_SECONDS, 8'h59);
            repeat (2 * SEC + 20) @(negedge clock); // Bytes trail counters by one tick
            cw(rtc_pkg::OFS_CONTROL, 8'h40);
            cw(rtc_pkg::OFS_SECONDS, 8'h30);
            repeat (2 * SEC + 20) @(negedge clock);
            cr(rtc_pkg::OFS_CONTROL, 8'h40);
            cr(rtc_pkg::OFS_SECONDS, 8'h30);
            cr(rtc_pkg::OFS_MINUTES, 8'h00);
            cr(rtc_pkg::OFS_HOURS, 8'h00);
            cr(rtc_pkg::OFS_DATE, cal[i][7:0]);
            cr(rtc_pkg::OFS_MONTH, cal[i][15:8]);
            cr(rtc_pkg::OFS_DAY, 8'(i + 2));
            cr(rtc_pkg::OFS_YEAR, cal[i][39:32]);
        end
        $display("test calendar done");
        testDone;
    end
    initial begin
        #(8 * 20000);
        nErrors++;
        testDone;
    end
    task automatic testDone;
        $display("checks %0d mismatches %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
endmodule // rtc_sram_clock_tb
`default_nettype wire
